// [hw/arc_pkg.sv]
// arc_pkg: addresses, field positions, reset values and codes of the analog
// reference control block.
// assumes an 8-bit special-function-register bus and a 16-bit code memory space.
package arc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // special-function-register addresses
  localparam logic [7:0] ARC_REF_CTRL_ADDR = 8'hD1; // reference_control_reg
  localparam logic [7:0] ARC_REG_CTRL_ADDR = 8'hC9; // regulator_control_reg

  // reference_control_reg field positions
  localparam int ARC_BUF_EN_BIT   = 0;  // ref_buffer_drive_enable
  localparam int ARC_BIAS_EN_BIT  = 1;  // bias_gen_enable
  localparam int ARC_TEMP_EN_BIT  = 2;  // temp_sensor_enable
  localparam int ARC_SRC_SEL_BIT  = 3;  // ref_source_select
  localparam int ARC_REG_OVR_BIT  = 4;  // regulator_ref_override
  localparam int ARC_GAIN_SEL_BIT = 7;  // ref_buffer_gain_select

  // writable bits of reference_control_reg; bits 6:5 read as zero
  localparam logic [7:0] ARC_REF_CTRL_WMASK = 8'h9F;
  localparam logic [7:0] ARC_REF_CTRL_RESET = 8'h00;

  // regulator_control_reg: only the input_regulator_disable bit lives here
  localparam int         ARC_REG_DIS_BIT    = 7;
  localparam logic       ARC_REG_DIS_RESET  = 1'b0;
  localparam logic [7:0] ARC_BYTE_ZERO      = 8'h00;

  // code memory locations of the temperature offset constant
  localparam logic [15:0] ARC_TOFF_HI_ADDR = 16'h3FFB; // temp_offset_high
  localparam logic [15:0] ARC_TOFF_LO_ADDR = 16'h3FFA; // temp_offset_low
  localparam int          ARC_TOFF_WIDTH   = 10;
  localparam int          ARC_TOFF_LO_BITS = 2;      // in bits 7:6 of the low byte

  // adc_positive_channel_select code routing the temperature sensor
  localparam logic [4:0] ARC_TEMP_CHANNEL = 5'h1E;

  // reference source routed to the adc
  typedef enum logic [1:0] {
    ARC_REF_PIN  = 2'b00,  // external reference pin
    ARC_REF_VDD  = 2'b01,  // unregulated supply
    ARC_REF_CORE = 2'b10   // internal core_regulator
  } arc_ref_e;

endpackage : arc_pkg

// [hw/arc_cal_if.sv]
// arc_cal_if: read port between the control logic and the calibration store.
// assumes one clock for both ends.
`timescale 1ns/10ps
interface arc_cal_if;
  logic [15:0] addr;   // code memory byte address
  logic        rd;     // read strobe
  logic [7:0]  rdata;  // registered read data

  modport ctrl (output addr, output rd, input rdata);
  modport store (input addr, input rd, output rdata);
endinterface : arc_cal_if

// [hw/arc_cal_store.sv]
// arc_cal_store: the two code memory bytes holding the temperature offset.
// assumes reads are strobed for one cycle; data appear one cycle later.
`timescale 1ns/10ps
module arc_cal_store
  import arc_pkg::*;
#(
  // factory offset code, arbitrary neutral default
  parameter logic [9:0] TEMP_OFFSET_CODE = 10'h200
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  arc_cal_if.store  cal
);

  ////////////////////////////////////////////////////////////////////////////////
  // left-justified packing of the offset
  localparam int LOW_PAD = 8 - ARC_TOFF_LO_BITS;
  wire logic [7:0] hi_byte = TEMP_OFFSET_CODE[ARC_TOFF_WIDTH-1:ARC_TOFF_LO_BITS];
  wire logic [7:0] lo_byte = {TEMP_OFFSET_CODE[ARC_TOFF_LO_BITS-1:0],
                              {LOW_PAD{1'b0}}};

  // address selection, other addresses read zero
  wire logic [7:0] rd_next = (cal.addr == ARC_TOFF_HI_ADDR) ? hi_byte :
                             (cal.addr == ARC_TOFF_LO_ADDR) ? lo_byte : ARC_BYTE_ZERO;

  // registered read data
  logic [7:0] rdata_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= ARC_BYTE_ZERO;
    end else if (cal.rd) begin
      rdata_reg <= rd_next;
    end
  end

  assign cal.rdata = rdata_reg;

endmodule // arc_cal_store

// [hw/arc_top.sv]
// arc_top: reference control register, regulator disable bit, reference
// routing controls and the temperature offset read port.
// assumes a single-cycle special-function-register bus on sys_clk and analog
// circuits that follow the control levels driven here.
//
// Function
// - source select bit 0 picks reference pin, 1 picks unregulated supply.
// - override bit set picks core regulator regardless of source select.
// - temperature sensor powered exactly while its enable bit is one.
// - disabled temperature sensor leaves its output at high impedance.
// - bias generator on if enable bit or any peripheral requests bias.
// - gain select 0 gives 2x buffer gain, 1 gives 1x.
// - buffer enable bit powers buffer and drives its output on reference pin.
// - unused bits 6:5 read zero and ignore writes.
// - 10-bit left-justified offset: high byte upper eight, low bits 7:6 rest.
// - stored offset equals adc code of sensor at zero celsius.
// - software enables or disables input regulator via a control bit.
// - regulator disable bit 0 keeps regulator on, 1 turns it off.
// - channel code 11110 connects the temperature sensor to adc input.
`timescale 1ns/10ps
module arc_top
  import arc_pkg::*;
#(
  // factory offset code, arbitrary neutral default
  parameter logic [9:0] TEMP_OFFSET_CODE = 10'h200
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // special-function-register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // code memory read port for the calibration bytes
  input  wire logic [15:0] code_addr,
  input  wire logic       code_rd,
  output logic      [7:0] code_rdata,
  // peripherals asking for analog bias
  input  wire logic       bias_request,
  // adc multiplexer channel code
  input  wire logic [4:0] adc_positive_channel_select,
  // analog controls
  output arc_ref_e        adc_ref_source,
  output logic            ref_buffer_on,
  output logic            ref_buffer_gain_2x,
  output logic            vref_pin_drive,
  output logic            temp_sensor_on,
  output logic            temp_out_hiz,
  output logic            temp_to_adc,
  output logic            bias_gen_on,
  output logic            input_regulator_on
);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  wire logic ref_hit = addr_hit(sfr_addr, ARC_REF_CTRL_ADDR);
  wire logic reg_hit = addr_hit(sfr_addr, ARC_REG_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////////
  // reference_control_reg
  logic [7:0] ref_ctrl_reg;
  wire  logic [7:0] ref_ctrl_next = sfr_wdata & ARC_REF_CTRL_WMASK;

  // byte-wide write, cleared by reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ref_ctrl_reg <= ARC_REF_CTRL_RESET;
    end else if (sfr_wr && ref_hit) begin
      ref_ctrl_reg <= ref_ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // regulator_control_reg, input_regulator_disable bit only
  logic reg_dis_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_dis_reg <= ARC_REG_DIS_RESET;
    end else if (sfr_wr && reg_hit) begin
      reg_dis_reg <= sfr_wdata[ARC_REG_DIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, registered; unmapped addresses read zero
  wire logic [7:0] reg_ctrl_view = {reg_dis_reg, 7'h00};
  wire logic [7:0] rdata_next    = ref_hit ? ref_ctrl_reg :
                                   reg_hit ? reg_ctrl_view : ARC_BYTE_ZERO;

  logic [7:0] rdata_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= ARC_BYTE_ZERO;
    end else if (sfr_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // control bit views
  wire logic src_sel  = ref_ctrl_reg[ARC_SRC_SEL_BIT];
  wire logic ovr      = ref_ctrl_reg[ARC_REG_OVR_BIT];
  wire logic temp_en  = ref_ctrl_reg[ARC_TEMP_EN_BIT];
  wire logic bias_en  = ref_ctrl_reg[ARC_BIAS_EN_BIT];
  wire logic buf_en   = ref_ctrl_reg[ARC_BUF_EN_BIT];
  wire logic gain_sel = ref_ctrl_reg[ARC_GAIN_SEL_BIT];

  // reference routing, override wins over source select
  assign adc_ref_source = ovr     ? ARC_REF_CORE :
                          src_sel ? ARC_REF_VDD  : ARC_REF_PIN;

  // temperature sensor power, output tristate and mux routing
  assign temp_sensor_on = temp_en;
  assign temp_out_hiz   = !temp_en;
  assign temp_to_adc    = (adc_positive_channel_select == ARC_TEMP_CHANNEL);

  // bias generator: manual or automatic request
  assign bias_gen_on = bias_en | bias_request;

  // on-chip reference buffer
  assign ref_buffer_gain_2x = !gain_sel;
  assign ref_buffer_on      = buf_en;
  assign vref_pin_drive     = buf_en;

  // input regulator enable
  assign input_regulator_on = !reg_dis_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // calibration store
  arc_cal_if cal_bus ();

  assign cal_bus.addr = code_addr;
  assign cal_bus.rd   = code_rd;
  assign code_rdata   = cal_bus.rdata;

  arc_cal_store #(
    .TEMP_OFFSET_CODE (TEMP_OFFSET_CODE)
  ) u_cal_store (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .cal     (cal_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  source_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit && !sfr_wdata[ARC_REG_OVR_BIT]) |=>
      (adc_ref_source == ($past(sfr_wdata[ARC_SRC_SEL_BIT]) ? ARC_REF_VDD : ARC_REF_PIN)))
    else $error("reference source does not follow source select");

  override_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit && sfr_wdata[ARC_REG_OVR_BIT]) |=> (adc_ref_source == ARC_REF_CORE))
    else $error("override did not select core regulator");

  temp_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit) |=> (temp_sensor_on == $past(sfr_wdata[ARC_TEMP_EN_BIT])))
    else $error("temperature sensor power does not follow enable");

  temp_hiz_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit) |=> (temp_out_hiz == !$past(sfr_wdata[ARC_TEMP_EN_BIT])))
    else $error("sensor output not tristated while off");

  bias_or_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bias_request || ref_ctrl_reg[ARC_BIAS_EN_BIT]) == bias_gen_on)
    else $error("bias generator enable wrong");

  buffer_gain_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit) |=> (ref_buffer_gain_2x == !$past(sfr_wdata[ARC_GAIN_SEL_BIT])))
    else $error("buffer gain does not follow gain select");

  buffer_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit) |=> (ref_buffer_on == $past(sfr_wdata[ARC_BUF_EN_BIT]))
      && (vref_pin_drive == ref_buffer_on))
    else $error("buffer drive does not follow enable");

  unused_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_rd && ref_hit) |=> (sfr_rdata & ~ARC_REF_CTRL_WMASK) == ARC_BYTE_ZERO)
    else $error("unused bits read nonzero");

  readback_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && ref_hit) ##1 (sfr_rd && ref_hit && !sfr_wr) |=>
      (sfr_rdata == ($past(sfr_wdata, 2) & ARC_REF_CTRL_WMASK)))
    else $error("written byte not read back");

  offset_hi_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (code_rd && code_addr == ARC_TOFF_HI_ADDR) |=>
      (code_rdata == TEMP_OFFSET_CODE[ARC_TOFF_WIDTH-1:ARC_TOFF_LO_BITS]))
    else $error("offset high byte wrong");

  regulator_dis_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_wr && reg_hit) |=> (input_regulator_on == !$past(sfr_wdata[ARC_REG_DIS_BIT])))
    else $error("input regulator enable wrong");

  temp_channel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    temp_to_adc == (adc_positive_channel_select == ARC_TEMP_CHANNEL))
    else $error("temperature channel routing wrong");

  // low calibration byte carries the two least significant offset bits on top
  offset_lo_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (code_rd && code_addr == ARC_TOFF_LO_ADDR) |=>
      (code_rdata == {TEMP_OFFSET_CODE[ARC_TOFF_LO_BITS-1:0], 6'h00}))
    else $error("offset low byte wrong");

  // regulator control read shows the disable bit, the inverse of the enable
  regulator_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_rd && reg_hit) |=> (sfr_rdata[ARC_REG_DIS_BIT] != $past(input_regulator_on)))
    else $error("regulator disable bit read back wrong");

  // reads of addresses outside this block return zero
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sfr_rd && !ref_hit && !reg_hit) |=> (sfr_rdata == ARC_BYTE_ZERO))
    else $error("unmapped address read nonzero");

endmodule // arc_top

// [bench/arc_tb_top.sv]
// arc_tb_top: self-checking bench for arc_top, register bus, controls, calibration bytes.
// assumes arc_top, arc_cal_store, arc_cal_if and arc_pkg compiled before this file.
`timescale 1ns/10ps
module analog_reference_control_tb_top
  import arc_pkg::*;
;
  localparam logic [9:0] OFFSET = 10'h2C7; // arbitrary offset code for the test
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [15:0] code_addr;
  logic        code_rd;
  logic [7:0]  code_rdata;
  logic        bias_request;
  logic [4:0]  chan;
  arc_ref_e    adc_ref_source;
  logic        buf_on, gain_2x, pin_drive, temp_on, temp_hiz, temp_adc, bias_on, reg_on;
  logic [7:0]  sfr_q[$];
  logic [7:0]  code_q[$];
  logic        sfr_pend, code_pend;
  logic [7:0]  v;
  int          err_total, comparisons;

  arc_top #(.TEMP_OFFSET_CODE(OFFSET)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .code_addr(code_addr), .code_rd(code_rd), .code_rdata(code_rdata),
    .bias_request(bias_request), .adc_positive_channel_select(chan),
    .adc_ref_source(adc_ref_source), .ref_buffer_on(buf_on), .ref_buffer_gain_2x(gain_2x),
    .vref_pin_drive(pin_drive), .temp_sensor_on(temp_on), .temp_out_hiz(temp_hiz),
    .temp_to_adc(temp_adc), .bias_gen_on(bias_on), .input_regulator_on(reg_on));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask

  // note the expected byte, then strobe; the watcher compares it
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    sfr_q.push_back(exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
  endtask

  // write, then read back at the very next edge, as the bus allows
  task automatic sfr_write_read(input logic [7:0] a, input logic [7:0] d,
                                input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_q.push_back(exp);
    sfr_wr    <= 1'b0;
    sfr_rd    <= 1'b1;
    @(posedge sys_clk);
    sfr_rd    <= 1'b0;
  endtask

  task automatic code_read(input logic [15:0] a, input logic [7:0] exp);
    code_q.push_back(exp);
    @(posedge sys_clk);
    code_addr <= a;
    code_rd   <= 1'b1;
    @(posedge sys_clk);
    code_rd   <= 1'b0;
  endtask

  // analog controls against the register image x
  task automatic check_outs(input logic [7:0] x);
    logic [1:0] src;
    src = x[4] ? ARC_REF_CORE : (x[3] ? ARC_REF_VDD : ARC_REF_PIN);
    @(negedge sys_clk);
    check({6'h00, adc_ref_source}, {6'h00, src}, "ref source");
    check({7'h00, temp_on}, {7'h00, x[2]}, "temp on");
    check({7'h00, temp_hiz}, {7'h00, ~x[2]}, "temp hiz");
    check({7'h00, bias_on}, {7'h00, x[1] | bias_request}, "bias");
    check({7'h00, gain_2x}, {7'h00, ~x[7]}, "gain");
    check({6'h00, buf_on, pin_drive}, {6'h00, x[0], x[0]}, "buffer");
    check({7'h00, temp_adc}, {7'h00, chan == 5'h1E}, "temp channel");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: takes the oldest note when a read answer appears
  always @(posedge sys_clk) begin
    sfr_pend  <= sfr_rd;
    code_pend <= code_rd;
  end

  always @(negedge sys_clk) begin
    if (sfr_pend === 1'b1 && sfr_q.size() > 0) begin
      check(sfr_rdata, sfr_q.pop_front(), "register read");
    end
    if (code_pend === 1'b1 && code_q.size() > 0) begin
      check(code_rdata, code_q.pop_front(), "offset byte");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {resetn, sfr_wr, sfr_rd, code_rd, bias_request} = '0;
    {sfr_addr, sfr_wdata, code_addr, chan} = '0;
    err_total   = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    void'($urandom(52239));
    check_outs(8'h00);
    check({7'h00, reg_on}, 8'h01, "regulator after reset");
    sfr_read(ARC_REF_CTRL_ADDR, 8'h00);
    sfr_read(ARC_REG_CTRL_ADDR, 8'h00);
    $display("test reset done");
    // random bytes, unused bits included, with bias and channel moving
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom());
      bias_request <= 1'($urandom());
      chan <= (i % 3 == 0) ? 5'h1E : 5'($urandom());
      sfr_write(ARC_REF_CTRL_ADDR, v);
      check_outs(v & 8'h9F);
      sfr_read(ARC_REF_CTRL_ADDR, v & 8'h9F);
      sfr_write_read(ARC_REF_CTRL_ADDR, ~v, ~v & ARC_REF_CTRL_WMASK);
    end
    $display("test reference control done");
    sfr_write(ARC_REG_CTRL_ADDR, 8'hFF);
    @(negedge sys_clk);
    check({7'h00, reg_on}, 8'h00, "regulator off");
    sfr_read(ARC_REG_CTRL_ADDR, 8'h80);
    sfr_write(ARC_REG_CTRL_ADDR, 8'h7F);
    @(negedge sys_clk);
    check({7'h00, reg_on}, 8'h01, "regulator on");
    $display("test regulator done");
    sfr_write(ARC_REF_CTRL_ADDR, 8'h15);
    sfr_write(8'hD2, 8'hFF);
    sfr_read(8'hD2, 8'h00);
    sfr_read(ARC_REF_CTRL_ADDR, 8'h15);
    sfr_write(ARC_REF_CTRL_ADDR, 8'h14);
    check_outs(8'h14);
    $display("test unmapped done");
    code_read(16'h3FFB, OFFSET[9:2]);
    code_read(16'h3FFA, {OFFSET[1:0], 6'h00});
    code_read(16'h3FF9, 8'h00);
    $display("test offset done");
    sfr_write(ARC_REG_CTRL_ADDR, 8'h80);
    sfr_write(ARC_REF_CTRL_ADDR, 8'h9F);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    check_outs(8'h00);
    check({7'h00, reg_on}, 8'h01, "regulator after second reset");
    sfr_read(ARC_REF_CTRL_ADDR, 8'h00);
    $display("test second reset done");
    for (int i = 0; i < 10 && (sfr_q.size() + code_q.size()) > 0; i++) begin
      @(posedge sys_clk);
    end
    if ((sfr_q.size() + code_q.size()) > 0) begin
      err_total++;
      $display("unexpected at %0t: read answers missing", $time);
    end
    wrap_up();
  end
endmodule // analog_reference_control_tb_top
